// *** hdl/scrl_sync_release.v ***
/*
  synchrocheck release: compares the bus side with the line side for
  magnitude, slip and angle, and releases a breaker close when all
  three agree, when an enabled dead/live override applies, or when the
  bypass is set. optional transformer correction and close advance.
  assumes: one set of measured values per sample_valid_in pulse, all
  inputs synchronous to clock_in, settings held static while running.

  // Contract
  // - bus quantities come from inputs one to three, line from input four.
  // - a setting selects which bus phase the line input is compared with.
  // - bus inputs are phase-to-neutral or phase-to-phase per configuration.
  // - slip is the absolute difference of bus and line frequency.
  // - synchronous only while magnitude, slip and angle are all in limits.
  // - machine-to-grid releases early by the breaker closing time.
  // - grid-to-grid uses the same three checks without any advance.
  // - supervises manual, automatic or both close requests per setting.
  // - enabled dead/live bus/line conditions release without synchronism.
  // - external bypass forces release; its user secures synchronism.
  // - transformer mode corrects amplitude and/or angle before comparing.
  // - amplitude correction scales by the line/bus voltage ratio.
  // - angle correction is +30 deg times group, minus if primary on line.
*/
`timescale 1ns/100ps
`default_nettype none
`include "scrl_map.vh"

module scrl_sync_release (
  input wire clock_in,
  input wire rst_in,
  // measured values, one set per pulse
  input wire sample_valid_in,
  input wire [`SCRL_MAG_W-1:0] bus_mag1_in,
  input wire [`SCRL_MAG_W-1:0] bus_mag2_in,
  input wire [`SCRL_MAG_W-1:0] bus_mag3_in,
  input wire [`SCRL_ANG_W-1:0] bus_ang1_in,
  input wire [`SCRL_ANG_W-1:0] bus_ang2_in,
  input wire [`SCRL_ANG_W-1:0] bus_ang3_in,
  input wire [`SCRL_FRQ_W-1:0] bus_freq_in,
  input wire [`SCRL_MAG_W-1:0] line_voltage_input_mag_in,
  input wire [`SCRL_ANG_W-1:0] line_voltage_input_ang_in,
  input wire [`SCRL_FRQ_W-1:0] line_freq_in,
  // configuration
  input wire [1:0] phase_sel_in,
  input wire bus_phase_to_phase_in,
  input wire synchronization_scheme_in,
  input wire [`SCRL_MAG_W-2:0] magnitude_limit_in,
  input wire [`SCRL_FRQ_W-1:0] slip_limit_in,
  input wire [`SCRL_ANG_W-1:0] phase_limit_in,
  input wire [`SCRL_TCL_W-1:0] breaker_close_time_in,
  input wire supervise_manual_in,
  input wire supervise_auto_in,
  input wire live_bus_dead_line_in,
  input wire dead_bus_live_line_in,
  input wire dead_bus_dead_line_in,
  input wire [`SCRL_MAG_W-1:0] live_level_in,
  input wire [`SCRL_MAG_W-1:0] dead_level_in,
  input wire transformer_mode_in,
  input wire amp_corr_en_in,
  input wire ang_corr_en_in,
  input wire [15:0] line_bus_ratio_in,
  input wire [3:0] vector_group_in,
  input wire primary_line_side_in,
  input wire bypass_in,
  // close requests from the breaker control
  input wire manual_close_in,
  input wire auto_close_in,
  // results
  output reg synchronous_out,
  output reg release_out,
  output reg manual_close_out,
  output reg auto_close_out,
  output reg [`SCRL_FRQ_W-1:0] slip_out,
  output reg signed [14:0] angle_diff_out
);

  // synchronization_scheme_in codes
  localparam GRID_TO_GRID = 1'b0;
  localparam MACHINE_TO_GRID = 1'b1;

  reg [`SCRL_MAG_W-1:0] bus_mag;
  reg [`SCRL_ANG_W-1:0] bus_ang;
  reg [31:0] scaled_prod;
  reg [`SCRL_MAG_W:0] bus_scaled;
  reg signed [`SCRL_MAG_W+1:0] mag_dev_d;
  reg signed [`SCRL_FRQ_W:0] frq_dev;
  reg [`SCRL_FRQ_W-1:0] slip_d;
  reg [12:0] corr_abs;
  reg signed [14:0] corr;
  reg signed [14:0] ang_raw;
  reg signed [14:0] ang_now;
  reg signed [40:0] adv_prod;
  reg signed [24:0] adv_full;
  reg signed [14:0] adv;
  reg signed [14:0] ang_dev_d;
  reg bus_live_d;
  reg bus_dead_d;
  reg line_live_d;
  reg line_dead_d;

  reg signed [`SCRL_MAG_W+1:0] mag_dev_q;
  reg signed [`SCRL_FRQ_W:0] frq_dev_q;
  reg signed [14:0] ang_dev_q;
  reg bus_live_q;
  reg bus_dead_q;
  reg line_live_q;
  reg line_dead_q;
  reg stage_q;

  wire mag_ok;
  wire slip_ok;
  wire ang_ok;

  // brings an angle difference back into -180.0 .. +180.0 degrees
  function signed [14:0] wrap_angle;
    input signed [14:0] a;
    reg signed [14:0] r;
    begin
      r = a;
      if (r < -`SCRL_ANG_HALF) begin
        r = r + `SCRL_ANG_FULL;
      end
      if (r < -`SCRL_ANG_HALF) begin
        r = r + `SCRL_ANG_FULL;
      end
      if (r > `SCRL_ANG_HALF) begin
        r = r - `SCRL_ANG_FULL;
      end
      if (r > `SCRL_ANG_HALF) begin
        r = r - `SCRL_ANG_FULL;
      end
      wrap_angle = r;
    end
  endfunction

  // pick the bus input that the line input is wired against
  always @* begin
    case (phase_sel_in)
      `SCRL_SEL_P2: begin
        bus_mag = bus_mag2_in;
        bus_ang = bus_ang2_in;
      end
      `SCRL_SEL_P3: begin
        bus_mag = bus_mag3_in;
        bus_ang = bus_ang3_in;
      end
      default: begin
        bus_mag = bus_mag1_in;
        bus_ang = bus_ang1_in;
      end
    endcase
  end

  // live/dead states; with phase-to-phase inputs each value spans two
  // phases, so the bus counts live only if all three are live and dead
  // only if all three are dead, keeping one open phase from looking live
  always @* begin
    if (bus_phase_to_phase_in) begin
      bus_live_d = (bus_mag1_in >= live_level_in) &&
        (bus_mag2_in >= live_level_in) && (bus_mag3_in >= live_level_in);
      bus_dead_d = (bus_mag1_in <= dead_level_in) &&
        (bus_mag2_in <= dead_level_in) && (bus_mag3_in <= dead_level_in);
    end else begin
      bus_live_d = bus_mag >= live_level_in;
      bus_dead_d = bus_mag <= dead_level_in;
    end
    line_live_d = line_voltage_input_mag_in >= live_level_in;
    line_dead_d = line_voltage_input_mag_in <= dead_level_in;
  end

  // amplitude correction: bus scaled by the line/bus ratio; a product
  // past 17 bits saturates, so a wrapped value can never look in limit
  always @* begin
    scaled_prod = {16'h0000, bus_mag} * {16'h0000, line_bus_ratio_in};
    if (!(transformer_mode_in && amp_corr_en_in)) begin
      bus_scaled = {1'b0, bus_mag};
    end else if (|scaled_prod[31:`SCRL_RATIO_FRAC+`SCRL_MAG_W+1]) begin
      bus_scaled = 17'h1FFFF;
    end else begin
      bus_scaled = scaled_prod[`SCRL_RATIO_FRAC+`SCRL_MAG_W:`SCRL_RATIO_FRAC];
    end
    mag_dev_d = $signed({2'b00, line_voltage_input_mag_in}) -
      $signed({1'b0, bus_scaled});
  end

  // signed frequency deviation and slip
  always @* begin
    frq_dev = $signed({1'b0, line_freq_in}) - $signed({1'b0, bus_freq_in});
    if (frq_dev[`SCRL_FRQ_W]) begin
      slip_d = bus_freq_in - line_freq_in;
    end else begin
      slip_d = line_freq_in - bus_freq_in;
    end
  end

  // angle correction from the vector group, sign by primary side
  always @* begin
    corr_abs = {9'h000, vector_group_in} * {1'b0, `SCRL_ANG_STEP_VG};
    if (!(transformer_mode_in && ang_corr_en_in)) begin
      corr = 15'sh0000;
    end else if (primary_line_side_in) begin
      corr = -$signed({2'b00, corr_abs});
    end else begin
      corr = $signed({2'b00, corr_abs});
    end
    ang_raw = $signed({3'b000, line_voltage_input_ang_in}) -
      $signed({3'b000, bus_ang}) - corr;
    ang_now = wrap_angle(ang_raw);
  end

  // close advance: the angle reached after the breaker closing time;
  // clamped to half a turn so a large slip cannot alias the prediction
  always @* begin
    adv_prod = $signed({{24{frq_dev[`SCRL_FRQ_W]}}, frq_dev}) *
      $signed({25'h0000000, breaker_close_time_in}) *
      $signed({33'h000000000, `SCRL_ADV_GAIN});
    adv_full = adv_prod[`SCRL_ADV_SHIFT+24:`SCRL_ADV_SHIFT];
    if (adv_full > $signed({10'h000, `SCRL_ANG_HALF})) begin
      adv = `SCRL_ANG_HALF;
    end else if (adv_full < -$signed({10'h000, `SCRL_ANG_HALF})) begin
      adv = -`SCRL_ANG_HALF;
    end else begin
      adv = adv_full[14:0];
    end
    case (synchronization_scheme_in)
      MACHINE_TO_GRID: ang_dev_d = wrap_angle(ang_now + adv);
      GRID_TO_GRID: ang_dev_d = ang_now;
      default: ang_dev_d = ang_now;
    endcase
  end

  // stage one: capture the deviations of one sample set
  always @(posedge clock_in) begin
    if (rst_in) begin
      mag_dev_q <= 18'sh00000;
      frq_dev_q <= 17'sh00000;
      ang_dev_q <= 15'sh0000;
      bus_live_q <= 1'b0;
      bus_dead_q <= 1'b0;
      line_live_q <= 1'b0;
      line_dead_q <= 1'b0;
      slip_out <= 16'h0000;
      angle_diff_out <= 15'sh0000;
      stage_q <= 1'b0;
    end else begin
      stage_q <= sample_valid_in;
      if (sample_valid_in) begin
        mag_dev_q <= mag_dev_d;
        frq_dev_q <= frq_dev;
        ang_dev_q <= ang_dev_d;
        bus_live_q <= bus_live_d;
        bus_dead_q <= bus_dead_d;
        line_live_q <= line_live_d;
        line_dead_q <= line_dead_d;
        slip_out <= slip_d;
        angle_diff_out <= ang_now;
      end
    end
  end

  // stage two: the three limit checks
  scrl_limit_chk #(.W(`SCRL_MAG_W+2)) u_mag_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .update_in(stage_q),
    .dev_in(mag_dev_q),
    .limit_in({2'b00, magnitude_limit_in}),
    .within_out(mag_ok)
  );

  scrl_limit_chk #(.W(`SCRL_FRQ_W+1)) u_slip_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .update_in(stage_q),
    .dev_in(frq_dev_q),
    .limit_in(slip_limit_in),
    .within_out(slip_ok)
  );

  scrl_limit_chk #(.W(15)) u_ang_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .update_in(stage_q),
    .dev_in(ang_dev_q),
    .limit_in({2'b00, phase_limit_in}),
    .within_out(ang_ok)
  );

  // stage three: synchronism, overrides, bypass and close gating;
  // a failed quantity drops the indication on the next cycle, no hold
  always @(posedge clock_in) begin
    if (rst_in) begin
      synchronous_out <= 1'b0;
      release_out <= 1'b0;
      manual_close_out <= 1'b0;
      auto_close_out <= 1'b0;
    end else begin
      synchronous_out <= mag_ok && slip_ok && ang_ok;
      release_out <= (mag_ok && slip_ok && ang_ok) ||
        (live_bus_dead_line_in && bus_live_q && line_dead_q) ||
        (dead_bus_live_line_in && bus_dead_q && line_live_q) ||
        (dead_bus_dead_line_in && bus_dead_q && line_dead_q) ||
        bypass_in;
      manual_close_out <= manual_close_in &&
        (!supervise_manual_in || release_out);
      auto_close_out <= auto_close_in &&
        (!supervise_auto_in || release_out);
    end
  end

endmodule

`default_nettype wire

// *** shared/scrl_map.vh ***
/*
  constants of the synchrocheck release logic: widths, number formats
  and fixed arithmetic factors.
  assumes: included by bare name from the design files under hdl/.
*/
`ifndef SCRL_MAP_VH
`define SCRL_MAP_VH

// magnitudes are unsigned counts of one common voltage unit
`define SCRL_MAG_W 16
// frequencies are unsigned, in millihertz
`define SCRL_FRQ_W 16
// angles are unsigned tenths of a degree, 0 .. 3599
`define SCRL_ANG_W 12
// breaker closing time in milliseconds
`define SCRL_TCL_W 16

// one full turn and half a turn in tenths of a degree
`define SCRL_ANG_FULL 15'sh0E10
`define SCRL_ANG_HALF 15'sh0708
// angle step per vector group number, 30 degrees
`define SCRL_ANG_STEP_VG 12'h12C

// line/bus ratio is unsigned with 12 fraction bits (1.0 = 0x1000)
`define SCRL_RATIO_FRAC 12
`define SCRL_RATIO_ONE 16'h1000

// advance angle = mHz * ms * 3.6e-3 tenths of a degree,
// taken as mHz * ms * 236 / 2^16
`define SCRL_ADV_GAIN 8'hEC
`define SCRL_ADV_SHIFT 16

// phase select codes for the bus input matched to the line input
`define SCRL_SEL_P1 2'h0
`define SCRL_SEL_P2 2'h1
`define SCRL_SEL_P3 2'h2

`endif

// *** hdl/scrl_limit_chk.v ***
/*
  one limit check: flags a signed deviation whose absolute value lies
  within an unsigned limit; the flag is registered and refreshed only
  on the update strobe.
  assumes: the deviation and limit are stable while update_in is high.
*/
`timescale 1ns/100ps
`default_nettype none

module scrl_limit_chk #(
  parameter W = 16
) (
  input wire clock_in,
  input wire rst_in,
  input wire update_in,
  input wire signed [W-1:0] dev_in,
  input wire [W-2:0] limit_in,
  output reg within_out
);

  reg [W-1:0] mag;

  // absolute value, the most negative code saturates to the top
  always @* begin
    if (dev_in[W-1]) begin
      mag = -dev_in;
    end else begin
      mag = dev_in;
    end
  end

  // a saturated magnitude is never within any limit
  always @(posedge clock_in) begin
    if (rst_in) begin
      within_out <= 1'b0;
    end else if (update_in) begin
      within_out <= ~mag[W-1] && (mag[W-2:0] <= limit_in);
    end
  end

endmodule

`default_nettype wire

// *** bench/scrl_meas_model.sv ***
/*
  measurement side model: strobes capture of one measured set.
  assumes: the bench holds the measured values steady meanwhile.
*/
`timescale 1ns/100ps
`default_nettype none
module scrl_meas_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [3:0] gap_in,
  output var logic sample_valid_out
);
  logic [3:0] cnt_q;
  // one strobe every gap_in+1 cycles; gap 0 gives back to back sets
  always @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      cnt_q <= 4'h0;
      sample_valid_out <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == gap_in) ? 4'h0 : cnt_q + 4'h1;
      sample_valid_out <= (cnt_q == 4'h0);
    end
  end
endmodule
`default_nettype wire

// *** bench/scrl_sync_release_sva.sv ***
/*
  port checker of the synchrocheck release.
  assumes: bound to scrl_sync_release, one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module scrl_sync_release_sva (
  input wire clock_in,
  input wire rst_in,
  input wire sample_valid_in,
  input wire [15:0] bus_freq_in,
  input wire [15:0] line_freq_in,
  input wire [15:0] slip_limit_in,
  input wire [11:0] phase_limit_in,
  input wire synchronization_scheme_in,
  input wire supervise_manual_in,
  input wire supervise_auto_in,
  input wire live_bus_dead_line_in,
  input wire dead_bus_live_line_in,
  input wire dead_bus_dead_line_in,
  input wire bypass_in,
  input wire manual_close_in,
  input wire auto_close_in,
  input wire synchronous_out,
  input wire release_out,
  input wire manual_close_out,
  input wire auto_close_out,
  input wire [15:0] slip_out,
  input wire signed [14:0] angle_diff_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // expected slip and absolute angle, used by the properties only
  wire [15:0] slip_exp = (line_freq_in >= bus_freq_in) ?
    line_freq_in - bus_freq_in : bus_freq_in - line_freq_in;
  wire [14:0] ang_abs = angle_diff_out[14] ? -angle_diff_out : angle_diff_out;
  wire any_ovr = live_bus_dead_line_in | dead_bus_live_line_in |
    dead_bus_dead_line_in;

  slip_value_a:
    assert property (sample_valid_in |=> slip_out == $past(slip_exp))
    else $error("slip output is not the frequency difference");
  slip_hold_a:
    assert property (!sample_valid_in |=> $stable(slip_out))
    else $error("slip output moved without a sample");
  sync_release_a:
    assert property (synchronous_out |-> release_out)
    else $error("synchronous without release");
  slip_limit_a:
    assert property (synchronous_out |-> $past(slip_out, 2) <= slip_limit_in)
    else $error("synchronous with slip beyond limit");
  angle_limit_a:
    assert property (synchronous_out && !synchronization_scheme_in |->
      $past(ang_abs, 2) <= phase_limit_in)
    else $error("synchronous with angle beyond limit");
  bypass_force_a:
    assert property (bypass_in |=> release_out)
    else $error("bypass did not force release");
  override_only_a:
    assert property (release_out && !synchronous_out && !$past(bypass_in)
      |-> $past(any_ovr))
    else $error("release without cause");
  manual_gate_a:
    assert property (!$past(rst_in) |-> manual_close_out ==
      $past(manual_close_in && (release_out || !supervise_manual_in)))
    else $error("manual close gating wrong");
  auto_gate_a:
    assert property (!$past(rst_in) |-> auto_close_out ==
      $past(auto_close_in && (release_out || !supervise_auto_in)))
    else $error("auto close gating wrong");
endmodule
bind scrl_sync_release scrl_sync_release_sva chk_i (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .sample_valid_in(sample_valid_in),
  .bus_freq_in(bus_freq_in),
  .line_freq_in(line_freq_in),
  .slip_limit_in(slip_limit_in),
  .phase_limit_in(phase_limit_in),
  .synchronization_scheme_in(synchronization_scheme_in),
  .supervise_manual_in(supervise_manual_in),
  .supervise_auto_in(supervise_auto_in),
  .live_bus_dead_line_in(live_bus_dead_line_in),
  .dead_bus_live_line_in(dead_bus_live_line_in),
  .dead_bus_dead_line_in(dead_bus_dead_line_in),
  .bypass_in(bypass_in),
  .manual_close_in(manual_close_in),
  .auto_close_in(auto_close_in),
  .synchronous_out(synchronous_out),
  .release_out(release_out),
  .manual_close_out(manual_close_out),
  .auto_close_out(auto_close_out),
  .slip_out(slip_out),
  .angle_diff_out(angle_diff_out)
);
`default_nettype wire

// *** bench/tb.sv ***
/*
  bench of the synchrocheck release, driven through the measurement
  model. assumes: design files and scrl_map.vh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic run = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [15:0] bm1 = 16'h03E8, bm2 = 16'h03E8, bm3 = 16'h03E8;
  logic [15:0] lm = 16'h03E8, fb = 16'hC350, fl = 16'hC350;
  logic [15:0] slim = 16'h0064, tcl = 16'h0000, ratio = 16'h1000;
  logic [11:0] ba1 = 12'h000, ba2 = 12'h000, ba3 = 12'h000, la = 12'h000;
  logic [11:0] plim = 12'h032;
  logic [14:0] mlim = 15'h0064;
  logic [3:0] vg = 4'h0;
  logic [1:0] sel = 2'h0;
  logic p2p = 1'b0, m2g = 1'b0, sm = 1'b1, sa = 1'b1, xf = 1'b0;
  logic live_bus_dead_line = 1'b0, dead_bus_live_line = 1'b0, dead_bus_dead_line = 1'b0, ac = 1'b0, gc = 1'b0;
  logic pls = 1'b0, byp = 1'b0, mc = 1'b0, acl = 1'b0;
  // release expected from an enabled override while not synchronous
  logic ovr_x = 1'b0;
  wire sv, syn, rel, mco, aco;
  wire [15:0] slip;
  wire signed [14:0] ang;
  integer miscompares = 0, compares = 0, cycles = 0, i;

  // free clock; a slow hang is cut by the cycle ceiling
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end

  scrl_meas_model meas (.clock_in(clock_in), .rst_in(rst_in),
    .run_in(run), .gap_in(gap), .sample_valid_out(sv));
  // live and dead levels are the only tied inputs
  scrl_sync_release dut (.clock_in(clock_in), .rst_in(rst_in),
    .sample_valid_in(sv), .bus_mag1_in(bm1), .bus_mag2_in(bm2),
    .bus_mag3_in(bm3), .bus_ang1_in(ba1), .bus_ang2_in(ba2),
    .bus_ang3_in(ba3), .bus_freq_in(fb), .line_voltage_input_mag_in(lm),
    .line_voltage_input_ang_in(la), .line_freq_in(fl), .phase_sel_in(sel),
    .bus_phase_to_phase_in(p2p), .synchronization_scheme_in(m2g),
    .magnitude_limit_in(mlim), .slip_limit_in(slim), .phase_limit_in(plim),
    .breaker_close_time_in(tcl), .supervise_manual_in(sm),
    .supervise_auto_in(sa), .live_bus_dead_line_in(live_bus_dead_line),
    .dead_bus_live_line_in(dead_bus_live_line), .dead_bus_dead_line_in(dead_bus_dead_line),
    .live_level_in(16'h0320), .dead_level_in(16'h00C8),
    .transformer_mode_in(xf), .amp_corr_en_in(ac), .ang_corr_en_in(gc),
    .line_bus_ratio_in(ratio), .vector_group_in(vg),
    .primary_line_side_in(pls), .bypass_in(byp), .manual_close_in(mc),
    .auto_close_in(acl), .synchronous_out(syn), .release_out(rel),
    .manual_close_out(mco), .auto_close_out(aco), .slip_out(slip),
    .angle_diff_out(ang));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // run the strobe n cycles, then let the result reach the close outputs
  task go(input integer n);
    @(posedge clock_in) run <= 1'b1;
    repeat (n) @(posedge clock_in);
    run <= 1'b0;
    repeat (7) @(posedge clock_in);
    #1;
  endtask

  // same value on all bus inputs; judge sync and release together
  task smp(input logic [15:0] mb, ml, input logic [11:0] ab, al,
    input logic [15:0] f_b, f_l, input logic e);
    @(posedge clock_in);
    {bm1, bm2, bm3, lm} <= {mb, mb, mb, ml};
    {ba1, ba2, ba3, la} <= {ab, ab, ab, al};
    {fb, fl} <= {f_b, f_l};
    go(1);
    chk(syn, e);
    chk(rel, e | ovr_x);
  endtask

  task t_sync;
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h000, 16'hC3B4, 16'hC350, 1);
    chk(slip, 16'h0064);
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h000, 16'hC350, 16'hC3B5, 0);
    smp(16'h03E8, 16'h044D, 12'h000, 12'h000, 16'hC350, 16'hC350, 0);
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h033, 16'hC350, 16'hC350, 0);
    @(posedge clock_in) gap <= 4'h3;
    la <= 12'h032;
    go(12);
    chk(syn, 1);
    gap <= 4'h0;
    $display("t_sync done");
  endtask

  task t_phase;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clock_in) sel <= i[1:0];
      {ba1, ba2, ba3, la} <= {12'h384, 12'h000, 12'h384, 12'h000};
      go(1);
      chk(syn, i == 1);
    end
    @(posedge clock_in) sel <= 2'h0;
    $display("t_phase done");
  endtask

  task t_m2g;
    @(posedge clock_in) {m2g, tcl, slim} <= {1'b1, 16'h03E8, 16'h00C8};
    smp(16'h03E8, 16'h03E8, 12'h168, 12'h000, 16'hC350, 16'hC3B4, 1);
    chk({ang[14], ang}, 16'hFE98);
    @(posedge clock_in) tcl <= 16'h0000;
    smp(16'h03E8, 16'h03E8, 12'h168, 12'h000, 16'hC350, 16'hC3B4, 0);
    @(posedge clock_in) {m2g, tcl} <= {1'b0, 16'h03E8};
    smp(16'h03E8, 16'h03E8, 12'h168, 12'h000, 16'hC350, 16'hC3B4, 0);
    @(posedge clock_in) {tcl, slim} <= {16'h0000, 16'h0064};
    $display("t_m2g done");
  endtask

  task t_xfmr;
    @(posedge clock_in) {xf, gc, vg} <= {1'b1, 1'b1, 4'h5};
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h5DC, 16'hC350, 16'hC350, 1);
    chk({ang[14], ang}, 16'h0000);
    @(posedge clock_in) pls <= 1'b1;
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h5DC, 16'hC350, 16'hC350, 0);
    chk({ang[14], ang}, 16'hFDA8);
    // primary on line side: line lags by 150 deg, so the sign is flipped
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h834, 16'hC350, 16'hC350, 1);
    chk({ang[14], ang}, 16'h0000);
    @(posedge clock_in) {gc, pls, ac, ratio} <= {1'b0, 1'b0, 1'b1, 16'h0800};
    smp(16'h03E8, 16'h01F4, 12'h000, 12'h000, 16'hC350, 16'hC350, 1);
    @(posedge clock_in) xf <= 1'b0;
    smp(16'h03E8, 16'h01F4, 12'h000, 12'h000, 16'hC350, 16'hC350, 0);
    @(posedge clock_in) {ac, ratio, vg} <= {1'b0, 16'h1000, 4'h0};
    $display("t_xfmr done");
  endtask

  task t_ovr;
    @(posedge clock_in) live_bus_dead_line <= 1'b1;
    ovr_x = 1'b1;
    smp(16'h03E8, 16'h0000, 12'h000, 12'h000, 16'hC350, 16'h0000, 0);
    ovr_x = 1'b0;
    chk(rel, 1);
    smp(16'h0000, 16'h0000, 12'h000, 12'h000, 16'hC350, 16'h0000, 0);
    @(posedge clock_in) {live_bus_dead_line, dead_bus_dead_line} <= 2'b01;
    go(1);
    chk(rel, 1);
    @(posedge clock_in) {dead_bus_dead_line, dead_bus_live_line, bm2, bm3} <= {2'b01, 16'h03E8, 16'h03E8};
    lm <= 16'h03E8;
    go(1);
    chk(rel, 1);
    @(posedge clock_in) p2p <= 1'b1;
    go(1);
    chk(rel, 0);
    @(posedge clock_in) {p2p, dead_bus_live_line} <= 2'b00;
    $display("t_ovr done");
  endtask

  task t_close;
    smp(16'h03E8, 16'h03E8, 12'h000, 12'h000, 16'hC350, 16'h0000, 0);
    @(posedge clock_in) {byp, mc, acl} <= 3'b111;
    repeat (3) @(posedge clock_in);
    #1 chk({rel, mco, aco}, 3'b111);
    @(posedge clock_in) byp <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 chk({rel, mco, aco}, 3'b000);
    @(posedge clock_in) sm <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 chk({mco, aco}, 2'b10);
    @(posedge clock_in) {sm, sa} <= 2'b10;
    repeat (3) @(posedge clock_in);
    #1 chk({mco, aco}, 2'b01);
    @(posedge clock_in) {sa, mc, acl} <= 3'b100;
    $display("t_close done");
  endtask

  // reset in mid-run clears every output, then bypass acts again
  task t_rst;
    @(posedge clock_in) {byp, mc, acl} <= 3'b111;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1 chk({syn, rel, mco, aco}, 4'h0);
    chk(slip, 16'h0000);
    @(posedge clock_in) rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 chk({syn, rel, mco, aco}, 4'h7);
    @(posedge clock_in) {byp, mc, acl} <= 3'b000;
    $display("t_rst done");
  endtask

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    t_sync;
    t_phase;
    t_m2g;
    t_xfmr;
    t_ovr;
    t_close;
    t_rst;
    final_report;
  end
endmodule
`default_nettype wire
